// file: rtl/capture_phase_align_and_channel_mux.sv
// Pin filter, word FIFO and the capture phase alignment / channel mux top.
// Assumes every board pin is asynchronous to clk_i and buttons read 1 when pressed.
`timescale 1ns/1ps
`default_nettype none
`include "capture_align_regs.svh"

module pin_filter #(
	parameter int W = 1,
	parameter int HOLD = 0
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] pin_i,
	output logic [W-1:0] level_o
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1 <= '0;
			s2 <= '0;
			s3 <= '0;
		end else begin
			s1 <= pin_i;
			s2 <= s1;
			s3 <= s2;
		end
	end
	// Per-bit counter so one bouncing jumper cannot hold up another
	for (genvar b = 0; b < W; b++) begin : g_bit
		logic [16:0] cnt;
		wire agree = (s2[b] == s3[b]);
		wire done = (cnt >= 17'(HOLD));
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				cnt <= '0;
				level_o[b] <= 1'b0;
			end else if (!agree || s3[b] == level_o[b]) begin
				cnt <= '0;
			end else if (done) begin
				cnt <= '0;
				level_o[b] <= s3[b];
			end else begin
				cnt <= cnt + 17'h00001;
			end
		end
	end
endmodule : pin_filter

module word_fifo #(
	parameter int WIDTH = 28,
	parameter int DEPTH = 16
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wr_ptr;
	logic [AW:0] rd_ptr;
	wire full = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
	wire empty = (wr_ptr == rd_ptr);
	wire push = in_valid_i && !full;
	wire pop = out_ready_i && !empty;
	assign in_ready_o = !full;
	assign out_valid_o = !empty;
	assign out_data_o = mem[rd_ptr[AW-1:0]];
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data_i;
		end
	end
endmodule : word_fifo

module capture_phase_align_and_channel_mux #(
	parameter bit EIGHT_BIT_BUILD = 1'b0,
	parameter int STEP_FRAMES = `STEP_FRAMES,
	parameter int DEBOUNCE_CYCLES = `DEBOUNCE_CYCLES
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic serial_bit_clock_in_i,
	input wire logic frame_clock_in_i,
	input wire logic [3:0] adc_serial_i,
	input wire logic timing_reset_button_i,
	input wire logic phase_step_button_i,
	input wire logic phase_direction_jumper_i,
	input wire logic width_select_hi_jumper_i,
	input wire logic width_select_lo_jumper_i,
	input wire logic pair_ab_select_jumper_i,
	input wire logic pair_cd_select_jumper_i,
	input wire logic pair_hold_i,
	output logic [13:0] pair_ab_data_o,
	output logic [13:0] pair_cd_data_o,
	output logic pair_ab_out_clock_o,
	output logic pair_cd_out_clock_o,
	output logic phase_range_led_o,
	output logic overrun_o
);
	// Configuration port wiring runs past this block on the board; nothing here touches it

	logic [6:0] fast;
	logic [6:0] slow;
	pin_filter #(.W(7), .HOLD(0)) u_fast (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({pair_hold_i, frame_clock_in_i, serial_bit_clock_in_i, adc_serial_i}),
		.level_o(fast)
	);
	pin_filter #(.W(7), .HOLD(DEBOUNCE_CYCLES)) u_slow (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({timing_reset_button_i, phase_step_button_i, phase_direction_jumper_i,
			width_select_hi_jumper_i, width_select_lo_jumper_i,
			pair_ab_select_jumper_i, pair_cd_select_jumper_i}),
		.level_o(slow)
	);
	wire [3:0] adc = fast[3:0];
	wire bclk = fast[4];
	wire fclk = fast[5];
	wire hold = fast[6];
	wire treset = slow[6];
	wire step_held = slow[5];
	wire dir_down = slow[4];
	wire sel_ab = slow[1];
	wire sel_cd = slow[0];
	wire capture_align_pkg::width_e width = capture_align_pkg::width_e'(slow[3:2]);

	logic bclk_q;
	logic fclk_q;
	logic treset_q;
	wire rise_ev = bclk && !bclk_q;
	wire fall_ev = !bclk && bclk_q;
	wire frame_edge = fclk && !fclk_q;
	wire tr_press = treset && !treset_q;

	// Phase offset and stepping
	localparam capture_align_pkg::phase_t DEFAULT_PHASE =
		EIGHT_BIT_BUILD ? `PHASE_DEFAULT_8BIT : `PHASE_DEFAULT_OTHER;
	capture_align_pkg::phase_t phase;
	logic [`PACE_BITS-1:0] pace;
	wire pace_end = (pace == `PACE_BITS'(STEP_FRAMES - 1));
	wire step_fire = step_held && frame_edge && pace_end;
	wire at_top = (phase == `PHASE_SAT);
	wire at_bottom = (phase == -`PHASE_SAT);
	// Saturate one past the limit so the overflow stays visible and reversible
	wire capture_align_pkg::phase_t stepped = dir_down ? (at_bottom ? phase : phase - 10'sd1)
		: (at_top ? phase : phase + 10'sd1);
	wire capture_align_pkg::phase_t next_phase = tr_press ? DEFAULT_PHASE
		: (step_fire ? stepped : phase);
	wire out_of_range = (phase > `PHASE_LIMIT) || (phase < -`PHASE_LIMIT);
	wire [`PACE_BITS-1:0] next_pace = (!step_held || tr_press) ? '0
		: (frame_edge ? (pace_end ? '0 : pace + 1'b1) : pace);

	// Offset becomes a tap of 0..15 fabric cycles after each bit clock edge
	wire [9:0] biased = 10'(phase) + `TAP_BIAS;
	wire [3:0] tap = out_of_range ? (phase[9] ? 4'h0 : `TAP_MAX) : biased[`TAP_LSB +: 4];

	logic [15:0] rise_dly;
	logic [15:0] fall_dly;
	wire cap_rise = rise_dly[tap];
	wire cap_fall = fall_dly[tap];

	logic [6:0] rise_sr [4];
	logic [6:0] fall_sr [4];
	capture_align_pkg::word_t word [4];
	capture_align_pkg::word_t mask;
	assign mask = (width == capture_align_pkg::WIDTH_8) ? 14'h00FF
		: (width == capture_align_pkg::WIDTH_10) ? 14'h03FF
		: (width == capture_align_pkg::WIDTH_12) ? 14'h0FFF : 14'h3FFF;

	for (genvar c = 0; c < 4; c++) begin : g_chan
		for (genvar k = 0; k < `HALF_BITS; k++) begin : g_bit
			assign word[c][2*k+1] = rise_sr[c][k] & mask[2*k+1];
			assign word[c][2*k] = fall_sr[c][k] & mask[2*k];
		end
		always_ff @(posedge clk_i or posedge rst_i) begin
			if (rst_i) begin
				rise_sr[c] <= '0;
				fall_sr[c] <= '0;
			end else begin
				if (cap_rise) begin
					rise_sr[c] <= {rise_sr[c][5:0], adc[c]};
				end
				if (cap_fall) begin
					fall_sr[c] <= {fall_sr[c][5:0], adc[c]};
				end
			end
		end
	end

	wire capture_align_pkg::word_t ab_word = sel_ab ? word[1] : word[0];
	wire capture_align_pkg::word_t cd_word = sel_cd ? word[3] : word[2];

	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [27:0] fifo_out_data;
	logic [1:0] div;
	wire pop = fifo_out_valid && !hold && (div == 2'h0);
	word_fifo #(.WIDTH(28), .DEPTH(`FIFO_DEPTH)) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.in_valid_i(frame_edge),
		.in_ready_o(fifo_in_ready),
		.in_data_i({ab_word, cd_word}),
		.out_valid_o(fifo_out_valid),
		.out_ready_i(pop),
		.out_data_o(fifo_out_data)
	);

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			bclk_q <= 1'b0;
			fclk_q <= 1'b0;
			treset_q <= 1'b0;
			rise_dly <= '0;
			fall_dly <= '0;
			phase <= DEFAULT_PHASE;
			pace <= '0;
			phase_range_led_o <= 1'b0;
		end else begin
			bclk_q <= bclk;
			fclk_q <= fclk;
			treset_q <= treset;
			rise_dly <= {rise_dly[14:0], rise_ev};
			fall_dly <= {fall_dly[14:0], fall_ev};
			phase <= next_phase;
			pace <= next_pace;
			phase_range_led_o <= out_of_range;
		end
	end

	// Output side; the frame-domain words leave on the pair clocks
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			div <= 2'h0;
			pair_ab_data_o <= '0;
			pair_cd_data_o <= '0;
			pair_ab_out_clock_o <= 1'b1;
			pair_cd_out_clock_o <= 1'b1;
			overrun_o <= 1'b0;
		end else begin
			div <= div + 2'h1;
			if (pop) begin
				pair_ab_data_o <= fifo_out_data[27:14];
				pair_cd_data_o <= fifo_out_data[13:0];
				pair_ab_out_clock_o <= 1'b0;
				pair_cd_out_clock_o <= 1'b0;
			end else if (div == `OUT_CLK_HIGH) begin
				// Rising edge sits mid-word so the FIFO board samples settled data
				pair_ab_out_clock_o <= 1'b1;
				pair_cd_out_clock_o <= 1'b1;
			end
			// A full buffer drops the frame; the flag survives until the next timing reset
			if (frame_edge && !fifo_in_ready) begin
				overrun_o <= 1'b1;
			end else if (tr_press) begin
				overrun_o <= 1'b0;
			end
		end
	end

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	AST_TRESET_DEFAULT: assert property (tr_press |=> phase == DEFAULT_PHASE)
		else $error("timing reset did not restore default phase");
	AST_DEFAULT_TAP: assert property ((phase == DEFAULT_PHASE) |->
		tap == (EIGHT_BIT_BUILD ? 4'h9 : 4'h7))
		else $error("default phase maps to wrong capture tap");
	AST_STEP_UP: assert property (step_fire && !dir_down && !tr_press && !at_top
		|=> phase == $past(phase) + 10'sd1)
		else $error("phase did not increment");
	AST_STEP_DOWN: assert property (step_fire && dir_down && !tr_press && !at_bottom
		|=> phase == $past(phase) - 10'sd1)
		else $error("phase did not decrement");
	AST_HELD_PACE: assert property (step_held && !tr_press && frame_edge && !pace_end
		|=> pace == $past(pace) + 1'b1)
		else $error("pacing stalled while button held");
	AST_STEP_ONLY_HELD: assert property (!step_held && !tr_press |=> $stable(phase))
		else $error("phase moved without the step button");
	AST_PACE_SPACING: assert property ($changed(phase) && !$past(tr_press)
		|-> $past(pace_end) && $past(frame_edge))
		else $error("phase step not on pacing boundary");
	AST_RANGE_LED: assert property (out_of_range |=> phase_range_led_o)
		else $error("range LED not lit");
	AST_LED_CLEAR: assert property (tr_press |=> ##1 !phase_range_led_o)
		else $error("range LED not cleared by timing reset");
	AST_MUX_AB: assert property (frame_edge && sel_ab |-> ab_word == word[1])
		else $error("pair AB mux wrong");
	AST_WIDTH_8: assert property (width == capture_align_pkg::WIDTH_8
		|-> ab_word[13:8] == 6'h00 && cd_word[13:8] == 6'h00)
		else $error("8-bit width leaks upper bits");
	AST_OUT_CLOCK: assert property (pop |=> !pair_ab_out_clock_o ##1
		!pair_cd_out_clock_o ##1 pair_ab_out_clock_o && pair_cd_out_clock_o)
		else $error("pair clock shape wrong");

	COV_STEP: cover property (step_fire);
	COV_OUT_OF_RANGE: cover property ($rose(phase_range_led_o));
	COV_POP: cover property (pop);
	COV_OVERRUN: cover property ($rose(overrun_o));
endmodule : capture_phase_align_and_channel_mux
`default_nettype wire

// file: rtl/capture_align_regs.svh
// Constants for the capture phase alignment and channel mux block.
// Assumes a single 125 MHz fabric clock; all board pins arrive asynchronously.
// Operation
// - Timing reset restores build default phase offset
// - Default offset +50 for 8-bit, else -10
// - Capture serial data at phase-shifted clock edges
// - Step button: jumper open increments, shorted decrements
// - Held button keeps stepping continuously
// - Phase offset signed, limit plus/minus 255
// - Offset not reported; only range LED shown
// - Out-of-range phase lights the range LED
// - Recover via timing reset or reversed stepping
// - One step per 2^19 frame periods
// - Converter configuration port passes untouched
// - Jumpers pick A/B and C/D channels
// - Eight seven-bit shift registers, four per edge
// - Two jumpers select 8/10/12/14-bit width
// - Mux in frame domain, one clock per pair
`ifndef CAPTURE_ALIGN_REGS_SVH
`define CAPTURE_ALIGN_REGS_SVH

`define CLK_PERIOD_NS 8
`define DEBOUNCE_NS 1000000
`define DEBOUNCE_CYCLES (`DEBOUNCE_NS / `CLK_PERIOD_NS)
`define PHASE_DEFAULT_8BIT (10'sh032)
`define PHASE_DEFAULT_OTHER (-10'sh00A)
`define PHASE_LIMIT (10'sh0FF)
`define PHASE_SAT (10'sh100)
`define TAP_BIAS (10'h100)
`define TAP_LSB 5
`define TAP_MAX (4'hF)
`define STEP_FRAMES 524288
`define PACE_BITS 20
`define WORD_BITS 14
`define HALF_BITS 7
`define FIFO_DEPTH 16
`define OUT_CLK_HIGH (2'h2)

`endif

// file: rtl/capture_align_pkg.sv
// Types shared by the capture phase alignment block.
// Assumes the constants header is included by users needing numbers.
`default_nettype none
package capture_align_pkg;
	typedef logic signed [9:0] phase_t;
	typedef enum logic [1:0] {WIDTH_8, WIDTH_10, WIDTH_12, WIDTH_14} width_e;
	typedef logic [13:0] word_t;
endpackage : capture_align_pkg
`default_nettype wire

// file: sim/adc_link_model.sv
// Behavioural quad converter link: bit clock, frame clock and four serial lanes.
// Assumes the bench picks the mode; each lane carries one constant level.
`timescale 1ns/1ps
`default_nettype none
module adc_link_model (
	input wire logic [1:0] mode_i,
	input wire logic [3:0] level_i,
	output logic bit_clk_o,
	output logic frame_clk_o,
	output logic [3:0] data_o
);
	// Constant lanes keep the check independent of where the eye lands
	initial begin
		bit_clk_o = 1'b0;
		frame_clk_o = 1'b0;
		data_o = 4'h0;
		forever begin
			if (mode_i == 2'h1) begin
				for (int h = 0; h < 14; h++) begin
					frame_clk_o = (h < 7);
					bit_clk_o = ~bit_clk_o;
					data_o = level_i;
					#62.5;
				end
			end else if (mode_i == 2'h2) begin
				// Frame only, for fast step pacing; bit clock stands still
				frame_clk_o = ~frame_clk_o;
				#40;
			end else begin
				frame_clk_o = 1'b0;
				#8;
			end
		end
	end
endmodule : adc_link_model
`default_nettype wire

// file: sim/tb.sv
// Bench for the capture phase alignment and channel mux block.
// Assumes adc_link_model on the link side and shortened pacing counts.
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [1:0] mode = 2'h0;
	logic [3:0] level = 4'h0;
	logic bclk, fclk, ck_ab, ck_cd, led, ovr;
	logic [3:0] sdata;
	logic trst = 1'b0, step = 1'b0, dir = 1'b0, whi = 1'b0, wlo = 1'b0;
	logic sab = 1'b0, scd = 1'b0, hold = 1'b0;
	logic [13:0] ab, cd;
	int n_mismatch = 0;
	int cmp_count = 0;
	int seed = 32'h89ba;
	int pops = 0;
	int pops_base = 0;
	// Integer model of the phase offset; saturates one past the limit like the design
	localparam int STEP_SIM = 4;
	int model_phase = -10;
	int model_pace = 0;
	always #4 clk_i = ~clk_i;
	always @(negedge ck_ab) pops++;
	adc_link_model LINK (.mode_i(mode), .level_i(level), .bit_clk_o(bclk),
		.frame_clk_o(fclk), .data_o(sdata));
	capture_phase_align_and_channel_mux #(.EIGHT_BIT_BUILD(1'b0), .STEP_FRAMES(STEP_SIM),
		.DEBOUNCE_CYCLES(2)) DUT (.clk_i(clk_i), .rst_i(rst_i),
		.serial_bit_clock_in_i(bclk), .frame_clock_in_i(fclk), .adc_serial_i(sdata),
		.timing_reset_button_i(trst), .phase_step_button_i(step),
		.phase_direction_jumper_i(dir), .width_select_hi_jumper_i(whi),
		.width_select_lo_jumper_i(wlo), .pair_ab_select_jumper_i(sab),
		.pair_cd_select_jumper_i(scd), .pair_hold_i(hold), .pair_ab_data_o(ab),
		.pair_cd_data_o(cd), .pair_ab_out_clock_o(ck_ab), .pair_cd_out_clock_o(ck_cd),
		.phase_range_led_o(led), .overrun_o(ovr));
	task automatic check(input logic [13:0] seen, input logic [13:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic final_report();
		$display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	// Right justified ones of the selected width, or zero
	function automatic logic [13:0] expect_word(input int w, input int lvl);
		return lvl ? 14'((1 << (8 + 2 * w)) - 1) : 14'h0000;
	endfunction : expect_word
	function automatic logic [13:0] led_exp();
		return 14'(model_phase > 255 || model_phase < -255);
	endfunction : led_exp
	task automatic pulse_trst();
		@(negedge clk_i) trst = 1'b1;
		repeat (10) @(negedge clk_i);
		trst = 1'b0;
		repeat (10) @(negedge clk_i);
		model_phase = -10;
		model_pace = 0;
	endtask : pulse_trst
	// Jumper first, so the debounced direction is settled before the press
	task automatic set_step(input logic v, input logic d);
		@(negedge clk_i) dir = d;
		repeat (20) @(negedge clk_i);
		step = v;
		repeat (10) @(negedge clk_i);
		if (!v) begin
			model_pace = 0;
		end
	endtask : set_step
	task automatic run_frames(input int n);
		@(negedge clk_i) mode = 2'h2;
		repeat (n) @(posedge fclk);
		@(negedge clk_i) mode = 2'h0;
		repeat (12) @(negedge clk_i);
		for (int f = 0; f < n; f++) begin
			if (step) begin
				model_pace++;
			end
			if (model_pace == STEP_SIM) begin
				model_pace = 0;
				if (dir && model_phase > -256) begin
					model_phase--;
				end else if (!dir && model_phase < 256) begin
					model_phase++;
				end
			end
		end
	endtask : run_frames
	// Tests take about 240 us; the limit leaves margin and stays near 50k cycles
	initial begin
		#400000;
		n_mismatch++;
		final_report();
	end
	initial begin
		repeat (3) @(posedge clk_i);
		@(negedge clk_i) rst_i = 1'b0;
		repeat (10) @(negedge clk_i);
		pulse_trst();
		for (int i = 0; i < 8; i++) begin
			@(negedge clk_i);
			{sab, whi, wlo} = 3'(i);
			scd = ~sab;
			level = 4'($random(seed));
			mode = 2'h1;
			repeat (8) @(posedge fclk);
			// Both pair clocks rise on one edge; look half a cycle later, clear of the race
			@(posedge ck_ab);
			@(negedge clk_i);
			check(ab, expect_word(i % 4, sab ? level[1] : level[0]));
			check(cd, expect_word(i % 4, scd ? level[3] : level[2]));
			check(14'(ck_cd), 14'h0001);
		end
		$display("Channel and width test done");
		@(negedge clk_i) mode = 2'h0;
		repeat (50) @(negedge clk_i);
		hold = 1'b1;
		repeat (8) @(negedge clk_i);
		run_frames(20);
		check(14'(ovr), 14'h0001);
		pops_base = pops;
		@(negedge clk_i) hold = 1'b0;
		repeat (150) @(negedge clk_i);
		check(14'(pops - pops_base), 14'h0010);
		pulse_trst();
		check(14'(ovr), 14'h0000);
		$display("Buffer test done");
		set_step(1'b1, 1'b1);
		run_frames(980);
		check(14'(led), led_exp());
		run_frames(10);
		check(14'(led), led_exp());
		set_step(1'b0, 1'b1);
		set_step(1'b1, 1'b0);
		run_frames(6);
		check(14'(led), led_exp());
		set_step(1'b0, 1'b0);
		set_step(1'b1, 1'b1);
		run_frames(6);
		check(14'(led), led_exp());
		set_step(1'b0, 1'b1);
		pulse_trst();
		check(14'(led), led_exp());
		set_step(1'b1, 1'b0);
		run_frames(1060);
		check(14'(led), led_exp());
		run_frames(10);
		check(14'(led), led_exp());
		set_step(1'b0, 1'b0);
		$display("Phase range test done");
		final_report();
	end
endmodule : tb
`default_nettype wire
